// [src/lvi_pkg.sv]
package lvi_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets on the control bus
   localparam logic [3:0] LVI_OFS_STATUS = 4'h0; // low_voltage_status
   localparam logic [3:0] LVI_OFS_CONFIG = 4'h4; // config_word_one
   localparam logic [3:0] LVI_OFS_EVENT  = 4'h8; // sticky events, write one to clear
   localparam logic [3:0] LVI_OFS_MASK   = 4'hc; // event mask

   ////////////////////////////////////////////////////////////////////////////
   // field positions in config_word_one
   localparam int LVI_BIT_STOP_EN  = 0; // monitor_stop_enable
   localparam int LVI_BIT_PWR_DOWN = 1; // monitor_power_down
   localparam int LVI_BIT_TRIP_SEL = 2; // trip_level_select
   localparam int LVI_BIT_RST_DIS  = 3; // monitor_reset_disable

   // field positions in the event register
   localparam int LVI_EVT_FALL = 0; // under-voltage flag set
   localparam int LVI_EVT_RISE = 1; // under-voltage flag cleared
   localparam int LVI_EVT_RST  = 2; // monitor reset began

   ////////////////////////////////////////////////////////////////////////////
   // values after reset
   localparam logic [3:0] LVI_CONFIG_RESET = 4'h0; // monitor on, low-supply trips
   localparam logic [2:0] LVI_MASK_RESET   = 3'h0;

   // axi response codes
   localparam logic [1:0] LVI_RESP_OKAY   = 2'h0;
   localparam logic [1:0] LVI_RESP_SLVERR = 2'h2;

   // power mode of the core
   typedef enum logic [1:0]
   {
      LVI_MODE_RUN  = 2'b00,
      LVI_MODE_WAIT = 2'b01,
      LVI_MODE_STOP = 2'b10
   } lvi_mode_type;

   // configuration bits grouped
   typedef struct packed
   {
      logic rst_dis;
      logic trip_sel;
      logic pwr_down;
      logic stop_en;
   } lvi_cfg_type;

   // comparator pair from the analog side
   typedef struct packed
   {
      logic below_fall;
      logic below_rise;
   } lvi_cmp_type;

endpackage

// [src/lvi_ctrl.sv]
`timescale 1ns/1ns
// Notes on behaviour
// - monitor enabled straight out of reset
// - monitor only while power-down bit clear
// - reset on falling trip unless disabled
// - stop-enable bit keeps monitor in stop
// - trip select picks high or low thresholds
// - trip select resets to low-supply mode
// - selecting high mode when low resets at once
// - reset held until above rising threshold
// - comparator drives read-only under-voltage flag
// - flag set below fall, clear above rise
// - reset_n_i clears the flag, a monitor reset leaves it set
// - monitor raises no interrupt of its own
// - monitor stays active in wait mode
// - stop activity needs power-down clear, stop set
module lvi_ctrl
(
   input  wire logic                  mclk_i,
   input  wire logic                  reset_n_i,
   // analog comparator, asynchronous to mclk_i
   input  wire lvi_pkg::lvi_cmp_type  cmp_i,
   input  wire lvi_pkg::lvi_mode_type mode_i,
   output logic                       trip_sel_o,
   output logic                       cmp_enable_o,
   output logic                       sys_reset_o,
   output logic                       wake_o,
   output logic                       irq_o,
   // axi4-lite slave
   input  wire logic [3:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [3:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   lvi_pkg::lvi_cmp_type cmp_meta_q;
   lvi_pkg::lvi_cmp_type cmp_sync_q;
   lvi_pkg::lvi_cfg_type cfg_q;
   logic                 flag_q;
   logic                 flag_d;
   logic                 rst_hold_q;
   logic                 active;
   logic                 below_fall;
   logic                 above_rise;
   logic [2:0]           evt_q;
   logic [2:0]           evt_set;
   logic [2:0]           mask_q;
   logic [3:0]           aw_addr_q;
   logic                 aw_have_q;
   logic [31:0]          w_data_q;
   logic [3:0]           w_strb_q;
   logic                 w_have_q;
   logic                 wr_fire;
   logic [2:0]           evt_clr;
   logic                 wr_cfg;
   logic                 wr_evt;
   logic                 wr_mask;
   logic                 wr_bad;
   logic [31:0]          rd_word;
   logic                 rd_err;

   ////////////////////////////////////////////////////////////////////////////
   // offset match, shared by the write decode and the read mux
   // one function, so that both paths always agree on the map
   function automatic logic reg_hit
   (
      input logic [3:0] addr,
      input logic [3:0] ofs
   );
      reg_hit = (addr == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // comparator synchroniser
   // the comparator runs free of mclk_i, so its levels may move at any time;
   // only the second stage is read, the first one may go metastable;
   // both stages clear to the supply-fine level during reset
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         cmp_meta_q <= '0;
         cmp_sync_q <= '0;
      end
      else
      begin
         cmp_meta_q <= cmp_i;
         cmp_sync_q <= cmp_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // monitor activity and threshold decoding
   // wait keeps the monitor whenever it is powered, stop only with the
   // stop-enable bit set as well; the unused mode code turns it off;
   // run needs no software step, the reset value leaves it powered
   always_comb
   begin
      unique case (mode_i)
         lvi_pkg::LVI_MODE_STOP: active = !cfg_q.pwr_down && cfg_q.stop_en;
         lvi_pkg::LVI_MODE_WAIT: active = !cfg_q.pwr_down;
         lvi_pkg::LVI_MODE_RUN:  active = !cfg_q.pwr_down;
         default:                active = 1'b0;
      endcase
   end

   assign below_fall   = active && cmp_sync_q.below_fall;
   assign above_rise   = !cmp_sync_q.below_rise;
   assign cmp_enable_o = active;
   assign trip_sel_o   = cfg_q.trip_sel;

   // flag follows hysteresis table
   // between the two thresholds neither branch fires and the flag keeps
   // its value; a sleeping monitor reads as no under-voltage, since its
   // comparator is unpowered and says nothing about the supply
   always_comb
   begin
      flag_d = flag_q;
      if (!active)
         flag_d = 1'b0;
      else if (below_fall)
         flag_d = 1'b1;
      else if (above_rise)
         flag_d = 1'b0;
   end

   // status flag register
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         flag_q <= 1'b0;
      else
         flag_q <= flag_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // monitor reset request with hysteresis
   // raising trip select moves both thresholds up, so a supply that was
   // fine can sit below the new falling one and the reset starts at once;
   // setting the reset-disable bit drops a pending request, and so does
   // a monitor that goes to sleep
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         rst_hold_q <= 1'b0;
      else if (!active || cfg_q.rst_dis)
         rst_hold_q <= 1'b0;
      else if (below_fall)
         rst_hold_q <= 1'b1;
      else if (above_rise)
         rst_hold_q <= 1'b0;
   end

   // outputs to the system reset and wake logic
   assign sys_reset_o = rst_hold_q;
   assign wake_o      = rst_hold_q && (mode_i != lvi_pkg::LVI_MODE_RUN);

   ////////////////////////////////////////////////////////////////////////////
   // sticky events and interrupt output
   // an event in the same cycle as its clear stays set
   assign evt_set[lvi_pkg::LVI_EVT_FALL] = flag_d && !flag_q;
   assign evt_set[lvi_pkg::LVI_EVT_RISE] = !flag_d && flag_q && active;
   assign evt_set[lvi_pkg::LVI_EVT_RST]  = below_fall && !cfg_q.rst_dis && !rst_hold_q;

   // write decode, every field sits in the low byte lane
   assign wr_cfg  = wr_fire && w_strb_q[0] && reg_hit(aw_addr_q, lvi_pkg::LVI_OFS_CONFIG);
   assign wr_evt  = wr_fire && w_strb_q[0] && reg_hit(aw_addr_q, lvi_pkg::LVI_OFS_EVENT);
   assign wr_mask = wr_fire && w_strb_q[0] && reg_hit(aw_addr_q, lvi_pkg::LVI_OFS_MASK);
   assign wr_bad  = aw_addr_q[1:0] != 2'h0; // misaligned byte address

   // one-to-clear strobe for the sticky events
   assign evt_clr = wr_evt ? w_data_q[2:0] : 3'h0;

   // sticky event register
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         evt_q <= 3'h0;
      else
         evt_q <= (evt_q & ~evt_clr) | evt_set; // set wins over clear
   end

   // bus-side summary only, the monitor itself never interrupts
   assign irq_o = |(evt_q & mask_q);

   ////////////////////////////////////////////////////////////////////////////
   // axi write channel capture
   // address and data are held apart, so either may come first; both
   // readies stay low until the response has been taken, which keeps
   // one write at most in flight
   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
   assign wr_fire       = aw_have_q && w_have_q;

   // write address holding register
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 4'h0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_have_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end
      else if (wr_fire)
         aw_have_q <= 1'b0;
   end

   // write data holding register
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         w_have_q <= 1'b0;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_have_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end
      else if (wr_fire)
         w_have_q <= 1'b0;
   end

   // config_word_one, software owned
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         cfg_q <= lvi_pkg::LVI_CONFIG_RESET;
      else if (wr_cfg)
         cfg_q <= w_data_q[3:0];
   end

   // event mask
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         mask_q <= lvi_pkg::LVI_MASK_RESET;
      else if (wr_mask)
         mask_q <= w_data_q[2:0];
   end

   // write response valid, held until taken
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         s_axi_bvalid <= 1'b0;
      else if (wr_fire)
         s_axi_bvalid <= 1'b1;
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // write response code, latched with the response
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         s_axi_bresp <= lvi_pkg::LVI_RESP_OKAY;
      else if (wr_fire)
         s_axi_bresp <= wr_bad ? lvi_pkg::LVI_RESP_SLVERR : lvi_pkg::LVI_RESP_OKAY;
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi read channel
   // the answer comes one edge after the address is taken and stands
   // until rready; a new address is refused while it stands, so the
   // data registers never change under a waiting master
   assign s_axi_arready = !s_axi_rvalid;

   // read mux, holes answer zero with an error
   always_comb
   begin
      rd_word = 32'h0;
      rd_err  = 1'b0;
      if (reg_hit(s_axi_araddr, lvi_pkg::LVI_OFS_STATUS))
         rd_word = {31'h0, flag_q};
      else if (reg_hit(s_axi_araddr, lvi_pkg::LVI_OFS_CONFIG))
         rd_word = {28'h0, cfg_q};
      else if (reg_hit(s_axi_araddr, lvi_pkg::LVI_OFS_EVENT))
         rd_word = {29'h0, evt_q};
      else if (reg_hit(s_axi_araddr, lvi_pkg::LVI_OFS_MASK))
         rd_word = {29'h0, mask_q};
      else
         rd_err = 1'b1;
   end

   // read answer valid, held until taken
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         s_axi_rvalid <= 1'b0;
      else if (s_axi_arvalid && s_axi_arready)
         s_axi_rvalid <= 1'b1;
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // read data and code, loaded when the address is taken
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= lvi_pkg::LVI_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_err ? lvi_pkg::LVI_RESP_SLVERR : lvi_pkg::LVI_RESP_OKAY;
      end
   end

endmodule

// [verif/lvi_ctrl_assertions.sv]
`timescale 1ns/1ns
module lvi_ctrl_assertions
(
   input wire logic                  mclk_i,
   input wire logic                  reset_n_i,
   input wire lvi_pkg::lvi_cmp_type  cmp_i,
   input wire lvi_pkg::lvi_mode_type mode_i,
   input wire logic                  trip_sel_o,
   input wire logic                  cmp_enable_o,
   input wire logic                  sys_reset_o,
   input wire logic                  wake_o,
   input wire logic                  s_axi_awvalid,
   input wire logic                  s_axi_awready,
   input wire logic                  s_axi_wvalid,
   input wire logic                  s_axi_wready,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_bready,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic                  s_axi_rvalid,
   input wire logic                  s_axi_rready,
   input wire logic [31:0]           s_axi_rdata
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);

   ////////////////////////////////////////////////////////////////////////////
   // steps of a write and of a supply recovery
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_above_rise;
      !cmp_i.below_rise [*4];
   endsequence
   property p_wr_answer;
      s_wr_take |-> ##[1:3] s_axi_bvalid;
   endproperty
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
   endproperty
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_rst_cause;
      $rose(sys_reset_o) |-> $past(cmp_i.below_fall, 3);
   endproperty
   property p_release;
      s_above_rise |=> !sys_reset_o;
   endproperty
   property p_hold;
      (cmp_i.below_rise [*4]) ##0 (sys_reset_o && cmp_enable_o) |=> sys_reset_o || !cmp_enable_o;
   endproperty
   property p_wake;
      wake_o == (sys_reset_o && mode_i != lvi_pkg::LVI_MODE_RUN);
   endproperty
   property p_inactive;
      !cmp_enable_o [*2] |-> !sys_reset_o;
   endproperty
   property p_out_of_reset;
      $rose(reset_n_i) |-> !trip_sel_o && (cmp_enable_o || mode_i != lvi_pkg::LVI_MODE_RUN);
   endproperty

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
   a_rhold: assert property (p_rhold) else $error("read answer not held");
   a_rst_cause: assert property (p_rst_cause) else $error("reset without fall trip");
   a_release: assert property (p_release) else $error("reset held above rise");
   a_hold: assert property (p_hold) else $error("reset released below rise");
   a_wake: assert property (p_wake) else $error("wake mismatch");
   a_inactive: assert property (p_inactive) else $error("reset while monitor off");
   a_out_of_reset: assert property (p_out_of_reset) else $error("bad state after reset");
endmodule

bind lvi_ctrl lvi_ctrl_assertions i_chk (.*);

// [verif/lvi_cmp_model.sv]
`timescale 1ns/1ns
module lvi_cmp_model
#(
   parameter int LO_FALL_MV = 2400,
   parameter int LO_RISE_MV = 2500,
   parameter int HI_FALL_MV = 3900,
   parameter int HI_RISE_MV = 4000
)
(
   input  wire logic [12:0]     vdd_mv_i,
   input  wire logic            trip_sel_i,
   input  wire logic            enable_i,
   output lvi_pkg::lvi_cmp_type cmp_o
);
   ////////////////////////////////////////////////////////////////////////////
   // threshold pair chosen by trip select, quiet while powered down
   always_comb
   begin
      cmp_o = 2'h0;
      if (enable_i)
      begin
         cmp_o.below_fall = int'(vdd_mv_i) < (trip_sel_i ? HI_FALL_MV : LO_FALL_MV);
         cmp_o.below_rise = int'(vdd_mv_i) < (trip_sel_i ? HI_RISE_MV : LO_RISE_MV);
      end
   end
endmodule

// [verif/tb_lvi_ctrl.sv]
`timescale 1ns/1ns
module tb_lvi_ctrl;
   logic                  mclk_i, reset_n_i, trip_sel_o, cmp_enable_o, sys_reset_o, wake_o, irq_o;
   lvi_pkg::lvi_cmp_type  cmp_i;
   lvi_pkg::lvi_mode_type mode_i;
   logic [3:0]            s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [31:0]           s_axi_wdata, s_axi_rdata, rd_q;
   logic [1:0]            s_axi_bresp, s_axi_rresp, resp_q;
   logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                  s_axi_rvalid, s_axi_rready;
   logic [12:0]           vdd_mv;
   int                    n_errors, num_checks;

   lvi_ctrl i_dut (.*);
   lvi_cmp_model i_cmp (.vdd_mv_i(vdd_mv), .trip_sel_i(trip_sel_o), .enable_i(cmp_enable_o),
                        .cmp_o(cmp_i));

   // 125 MHz clock
   always #4 mclk_i = ~mclk_i;

   ////////////////////////////////////////////////////////////////////////////
   // verdict and comparison
   task report_and_stop;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // one axi4-lite write (w=1) or read (w=0), ends settled at a falling edge
   task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      int   n;
      logic ta, tw, tr, dn;
      @(posedge mclk_i);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      for (n = 0; n < 40; n++)
      begin
         @(negedge mclk_i);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tr = s_axi_arvalid && s_axi_arready;
         dn = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
         resp_q = w ? s_axi_bresp : s_axi_rresp;
         rd_q = s_axi_rdata;
         @(posedge mclk_i);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tr) s_axi_arvalid <= 1'b0;
         if (dn) break;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      if (n == 40)
      begin
         n_errors++;
         report_and_stop();
      end
      @(negedge mclk_i);
   endtask

   // supply level and power mode, then wait out the synchroniser
   task sv(input logic [12:0] v, input lvi_pkg::lvi_mode_type m);
      @(posedge mclk_i);
      vdd_mv <= v;
      mode_i <= m;
      repeat (5) @(posedge mclk_i);
      @(negedge mclk_i);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // hang guard
   initial
   begin
      #400000;
      n_errors++;
      report_and_stop();
   end

   // main sequence
   initial
   begin
      mclk_i = 1'b0;
      reset_n_i = 1'b0;
      mode_i = lvi_pkg::LVI_MODE_RUN;
      vdd_mv = 13'hce4;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      s_axi_wstrb = 4'hf;
      n_errors = 0;
      num_checks = 0;
      repeat (20) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      @(negedge mclk_i);
      chk(32'(cmp_enable_o), 32'h1, "monitor on");
      chk(32'(trip_sel_o), 32'h0, "trip default");
      acc(1'b0, lvi_pkg::LVI_OFS_CONFIG, 32'h0);
      chk(rd_q, 32'h0, "config reset");
      acc(1'b1, lvi_pkg::LVI_OFS_MASK, 32'h7);
      sv(13'h8fc, lvi_pkg::LVI_MODE_RUN);
      chk(32'(sys_reset_o), 32'h1, "reset below fall");
      chk(32'(irq_o), 32'h1, "event irq");
      acc(1'b0, lvi_pkg::LVI_OFS_STATUS, 32'h0);
      chk(rd_q, 32'h1, "flag set");
      sv(13'h8fc, lvi_pkg::LVI_MODE_WAIT);
      chk(32'(wake_o), 32'h1, "wake from wait");
      sv(13'h992, lvi_pkg::LVI_MODE_RUN);
      chk(32'(sys_reset_o), 32'h1, "reset between");
      acc(1'b0, lvi_pkg::LVI_OFS_STATUS, 32'h0);
      chk(rd_q, 32'h1, "flag keeps");
      sv(13'ha28, lvi_pkg::LVI_MODE_RUN);
      chk(32'(sys_reset_o), 32'h0, "reset released");
      acc(1'b0, lvi_pkg::LVI_OFS_STATUS, 32'h0);
      chk(rd_q, 32'h0, "flag clear");
      acc(1'b0, lvi_pkg::LVI_OFS_EVENT, 32'h0);
      chk(rd_q, 32'h7, "events");
      acc(1'b1, lvi_pkg::LVI_OFS_EVENT, 32'h7);
      acc(1'b0, lvi_pkg::LVI_OFS_EVENT, 32'h0);
      chk(rd_q | 32'(irq_o), 32'h0, "events cleared");
      acc(1'b1, lvi_pkg::LVI_OFS_CONFIG, 32'h8);
      sv(13'h8fc, lvi_pkg::LVI_MODE_RUN);
      chk(32'(sys_reset_o), 32'h0, "reset disabled");
      acc(1'b0, lvi_pkg::LVI_OFS_STATUS, 32'h0);
      chk(rd_q, 32'h1, "polled flag");
      acc(1'b1, lvi_pkg::LVI_OFS_CONFIG, 32'h2);
      sv(13'h8fc, lvi_pkg::LVI_MODE_RUN);
      chk(32'(cmp_enable_o), 32'h0, "powered down");
      acc(1'b0, lvi_pkg::LVI_OFS_STATUS, 32'h0);
      chk(rd_q, 32'h0, "no flag when down");
      acc(1'b1, lvi_pkg::LVI_OFS_CONFIG, 32'h0);
      sv(13'h8fc, lvi_pkg::LVI_MODE_STOP);
      chk({31'h0, cmp_enable_o} | 32'(sys_reset_o), 32'h0, "stop off");
      acc(1'b1, lvi_pkg::LVI_OFS_CONFIG, 32'h1);
      sv(13'h8fc, lvi_pkg::LVI_MODE_STOP);
      chk(32'(cmp_enable_o), 32'h1, "stop on");
      chk(32'(wake_o), 32'h1, "wake from stop");
      sv(13'hbb8, lvi_pkg::LVI_MODE_RUN);
      acc(1'b1, lvi_pkg::LVI_OFS_CONFIG, 32'h4);
      chk(32'(trip_sel_o), 32'h1, "high trip");
      sv(13'hbb8, lvi_pkg::LVI_MODE_RUN);
      chk(32'(sys_reset_o), 32'h1, "reset on select");
      sv(13'h1004, lvi_pkg::LVI_MODE_RUN);
      chk(32'(sys_reset_o), 32'h0, "high release");
      @(posedge mclk_i);
      reset_n_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      @(negedge mclk_i);
      chk(32'(trip_sel_o), 32'h0, "trip after reset");
      acc(1'b0, lvi_pkg::LVI_OFS_STATUS, 32'h0);
      chk(rd_q, 32'h0, "flag after reset");
      acc(1'b0, 4'h2, 32'h0);
      chk(32'(resp_q), 32'(lvi_pkg::LVI_RESP_SLVERR), "bad read resp");
      chk(rd_q, 32'h0, "bad read data");
      acc(1'b1, 4'h6, 32'h1);
      chk(32'(resp_q), 32'(lvi_pkg::LVI_RESP_SLVERR), "bad write");
      report_and_stop();
   end
endmodule
